// ---- rtl/hbt_cnt.v ----
// hbt_cnt.v: one 32-bit wrapping packet counter.
// assumes: inc is a one-cycle pulse synchronous to pclk.
`default_nettype none
module hbt_cnt (
  input wire pclk,
  input wire presetn,
  input wire inc,
  output wire [31:0] count
);

  // ----------------------------------------
  // counter
  // ----------------------------------------
  reg [31:0] count_reg; // running count
  wire [31:0] count_next; // count plus one

  assign count_next = count_reg + 32'h0000_0001;
  assign count = count_reg;

  // count one per pulse, wrap at the top
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_reg <= 32'h0000_0000;
    else if (inc)
      count_reg <= count_next;
  end

endmodule
`default_nettype wire

// ---- rtl/hbt_consts.vh ----
// hbt_consts.vh: offsets, field positions and reset values of the
// host/bmc traffic steering block with its automatic arp responder.
// assumes: included by bare name from the rtl files of this block.
//
// Behaviour
// [R1] cleared net enable stops bmc-to-network only
// [R2] net blocked, host path on: bmc-to-host unfiltered
// [R3] host traffic still uses normal decision filters
// [R4] bmc enables channel only after an enable
// [R5] host-to-bmc stalls on transmit buffer flow control
// [R6] full receive buffer: drop or stall per policy
// [R7] manageability buffer full may drop packets
// [R8] host-to-bmc counted once as host transmit
// [R9] bmc-to-host counted received, also net-transmit
// [R10] four dedicated host/bmc packet counters
// [R11] link down stops all host-to-bmc traffic
// [R12] host path enabled by nvm or sideband
// [R13] host sends bmc no packet above 1.5 KB
// [R14] two independent per-port targets, no linkage
// [R15] per-port services configured separately
// [R16] bmc performs failover between ports itself
// [R17] arp offload, nvm filters only in smbus mode
// [R18] smbus mode: filters default from nvm
// [R19] arp settings from nvm and sideband writes
// [R20] matching arp request answered with configured mac
// [R21] non-matching arp request silently discarded
// [R22] auto-reply off: arp may pass to bmc
// [R23] both enabled: exact host, l2 pass both
// [R24] host path frames at most 1536 bytes
// [R25] arp reply leaves on the receiving port
`ifndef HBT_CONSTS_VH
`define HBT_CONSTS_VH

// ----------------------------------------
// address map: byte address = port * 0x40 + index * 4
// ----------------------------------------
`define HBT_PORT_BIT 6
`define HBT_I_CTRL 4'h0
`define HBT_I_ARP_IP 4'h1
`define HBT_I_MAC_LO 4'h2
`define HBT_I_MAC_HI 4'h3
`define HBT_I_FILTER 4'h4
`define HBT_I_STATUS 4'h5
`define HBT_I_CNT0 4'h6
`define HBT_I_LAST 4'hB
`define HBT_I_NONE 4'hF

// ----------------------------------------
// control register fields
// ----------------------------------------
`define HBT_C_NET 0
`define HBT_C_OS 1
`define HBT_C_PATH 2
`define HBT_C_ARP 3
`define HBT_C_AFWD 4
`define HBT_C_DROP 5
`define HBT_C_W 6

// ----------------------------------------
// reset values and limits
// ----------------------------------------
`define HBT_CTRL_RST 6'h00
`define HBT_IP_RST 32'h0000_0000
`define HBT_MAC_RST 48'h0000_0000_0000
`define HBT_FLT_RST 32'h0000_0000
`define HBT_MAX_FRAME 11'h600
`define HBT_NCNT 6

`endif

// ---- rtl/hbt_steer.v ----
// hbt_steer.v: host/bmc traffic steering, statistics and automatic
// arp responder for two lan ports, with an apb register file.
// assumes: packet events are one-cycle pulses synchronous to pclk;
// sideband and nvm write ports come from their own controllers.
//
// Added by the designer: the register offsets and register access over APB.
`include "hbt_consts.vh"
`default_nettype none
module hbt_steer (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire ncsi_mode,
  input wire [1:0] link_up,
  input wire [1:0] txbuf_xoff,
  input wire [1:0] rxbuf_full,
  input wire mng_full,
  input wire sb_wr,
  input wire [7:0] sb_addr,
  input wire [31:0] sb_data,
  input wire nvm_wr,
  input wire [7:0] nvm_addr,
  input wire [31:0] nvm_data,
  input wire htx_valid,
  input wire htx_port,
  input wire [10:0] htx_len,
  input wire htx_flt_bmc,
  input wire htx_flt_net,
  output wire [1:0] htx_ready,
  output wire htx_fwd_bmc,
  output wire htx_fwd_net,
  output wire htx_drop,
  output wire host_tx_stat,
  input wire bmc_took,
  input wire bmc_took_port,
  input wire btx_valid,
  input wire btx_port,
  input wire [10:0] btx_len,
  input wire btx_exact,
  input wire btx_l2_pass,
  output wire btx_fwd_host,
  output wire btx_fwd_net,
  output wire btx_drop,
  output wire btx_port_out,
  output wire host_rx_stat,
  output wire net_tx_stat,
  input wire host_rx_done,
  input wire host_rx_port,
  input wire nmg_valid,
  input wire nmg_port,
  output wire nmg_accept,
  input wire arp_valid,
  input wire arp_port,
  input wire arp_ok,
  input wire [31:0] arp_tip,
  output wire arp_reply,
  output wire arp_reply_port,
  output wire [47:0] arp_reply_mac,
  output wire arp_to_bmc
);

  // ----------------------------------------
  // address decode shared by the bus, sideband and nvm ports
  // ----------------------------------------
  // maps a byte address to a register index, none when unmapped
  function [3:0] hbt_dec;
    input [7:0] a;
    begin
      hbt_dec = `HBT_I_NONE;
      if (a[7] == 1'b0 && a[1:0] == 2'b00 && a[5:2] <= `HBT_I_LAST)
        hbt_dec = a[5:2];
    end
  endfunction

  // ----------------------------------------
  // per-port configuration store
  // ----------------------------------------
  reg [`HBT_C_W-1:0] ctrl_reg [0:1]; // steering and arp controls
  reg [31:0] ip_reg [0:1]; // arp filtering address
  reg [47:0] mac_reg [0:1]; // arp reply address
  reg [31:0] flt_reg [0:1]; // manageability receive filter set
  integer i;

  // ----------------------------------------
  // output flops
  // ----------------------------------------
  reg [31:0] prdata_reg;
  reg pready_reg;
  reg pslverr_reg;
  reg [1:0] htx_ready_reg;
  reg htx_fwd_bmc_reg;
  reg htx_fwd_net_reg;
  reg htx_drop_reg;
  reg host_tx_stat_reg;
  reg btx_fwd_host_reg;
  reg btx_fwd_net_reg;
  reg btx_drop_reg;
  reg btx_port_reg;
  reg host_rx_stat_reg;
  reg net_tx_stat_reg;
  reg nmg_accept_reg;
  reg arp_reply_reg;
  reg arp_port_reg;
  reg [47:0] arp_mac_reg;
  reg arp_to_bmc_reg;

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign htx_ready = htx_ready_reg;
  assign htx_fwd_bmc = htx_fwd_bmc_reg;
  assign htx_fwd_net = htx_fwd_net_reg;
  assign htx_drop = htx_drop_reg;
  assign host_tx_stat = host_tx_stat_reg;
  assign btx_fwd_host = btx_fwd_host_reg;
  assign btx_fwd_net = btx_fwd_net_reg;
  assign btx_drop = btx_drop_reg;
  assign btx_port_out = btx_port_reg;
  assign host_rx_stat = host_rx_stat_reg;
  assign net_tx_stat = net_tx_stat_reg;
  assign nmg_accept = nmg_accept_reg;
  assign arp_reply = arp_reply_reg;
  assign arp_reply_port = arp_port_reg;
  assign arp_reply_mac = arp_mac_reg;
  assign arp_to_bmc = arp_to_bmc_reg;

  // ----------------------------------------
  // write arbitration: bus before sideband before nvm
  // ----------------------------------------
  wire apb_we = psel & penable & pready_reg & pwrite; // bus write edge
  wire w_any = apb_we | sb_wr | nvm_wr; // some source writes
  wire w_nvm = ~apb_we & ~sb_wr; // nvm wins this cycle
  wire [7:0] w_addr = apb_we ? paddr : (sb_wr ? sb_addr : nvm_addr);
  wire [31:0] w_data = apb_we ? pwdata : (sb_wr ? sb_data : nvm_data);
  wire [3:0] w_idx = hbt_dec(w_addr); // target register
  wire w_port = w_addr[`HBT_PORT_BIT]; // target port bank

  // store writes; each port has its own bank with no shared state [R14]
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (i = 0; i < 2; i = i + 1)
      begin
        ctrl_reg[i] <= `HBT_CTRL_RST;
        ip_reg[i] <= `HBT_IP_RST;
        mac_reg[i] <= `HBT_MAC_RST;
        flt_reg[i] <= `HBT_FLT_RST;
      end
    end
    else if (w_any)
    begin
      case (w_idx)
        // host path enable from nvm or the sideband command
        `HBT_I_CTRL: ctrl_reg[w_port] <= w_data[`HBT_C_W-1:0]; // [R12] [R15]
        // arp settings loaded from nvm or written by the bmc
        `HBT_I_ARP_IP: ip_reg[w_port] <= w_data; // [R19]
        `HBT_I_MAC_LO: mac_reg[w_port][31:0] <= w_data; // [R19]
        `HBT_I_MAC_HI: mac_reg[w_port][47:32] <= w_data[15:0]; // [R19]
        `HBT_I_FILTER:
        begin
          // nvm filter defaults only take effect in smbus mode
          if (!(w_nvm && ncsi_mode))
            flt_reg[w_port] <= w_data; // [R18] [R17]
        end
        // status, counters and holes are not writable
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // path state per port
  // ----------------------------------------
  wire [1:0] path_on; // host path enabled and link up
  wire [1:0] rdy_next; // host transmit may be taken
  wire [11:0] inc; // counter pulses, six per port
  wire [31:0] cnt_val [0:11]; // counter values

  // ----------------------------------------
  // host transmit toward bmc and network
  // ----------------------------------------
  wire hp = htx_port;
  wire h_acc = htx_valid & htx_ready_reg[hp]; // packet taken
  // the decision filters choose the bmc; path off, link down or a frame over 1536 bytes closes it
  wire h_bmc = htx_flt_bmc & path_on[hp] & (htx_len <= `HBT_MAX_FRAME); // [R3] [R11] [R24]
  // receive buffer full, in either policy, or manageability buffer full
  wire h_room = ~mng_full & ~rxbuf_full[hp]; // [R6] [R7]

  // ----------------------------------------
  // bmc transmit toward host and network
  // ----------------------------------------
  wire bp = btx_port;
  wire b_net_en = ctrl_reg[bp][`HBT_C_NET]; // [R1]
  wire b_os_en = ctrl_reg[bp][`HBT_C_OS] & path_on[bp]; // [R11]
  wire b_ok = btx_valid & (btx_len <= `HBT_MAX_FRAME); // [R24]
  // net blocked, host path on: every packet within length to host with no filter check
  wire b_host = b_ok & b_os_en & (~b_net_en | btx_exact | btx_l2_pass); // [R2] [R23]
  // exact match stays with host; l2 fail goes only to net
  wire b_net = b_ok & b_net_en & (~b_os_en | ~btx_exact); // [R1] [R23]

  // ----------------------------------------
  // arp responder, smbus mode only
  // ----------------------------------------
  wire ap = arp_port;
  wire a_auto = ~ncsi_mode & ctrl_reg[ap][`HBT_C_ARP]; // [R17]
  wire a_hit = arp_ok & (arp_tip == ip_reg[ap]); // [R20] [R21]
  wire a_fwd = ~ncsi_mode & ~ctrl_reg[ap][`HBT_C_ARP] &
    ctrl_reg[ap][`HBT_C_AFWD]; // [R22]

  // ----------------------------------------
  // per-port counters and flow state
  // ----------------------------------------
  genvar gp;
  genvar gk;
  generate
    for (gp = 0; gp < 2; gp = gp + 1)
    begin : g_port
      wire me_h = (gp == 1) ? hp : ~hp; // host event on this port
      wire me_b = (gp == 1) ? bp : ~bp; // bmc event on this port
      wire me_t = (gp == 1) ? bmc_took_port : ~bmc_took_port;
      wire me_r = (gp == 1) ? host_rx_port : ~host_rx_port;
      wire me_n = (gp == 1) ? nmg_port : ~nmg_port;

      assign path_on[gp] = ctrl_reg[gp][`HBT_C_PATH] & link_up[gp]; // [R11] [R12]
      // stall on tx flow control, or rx full with stall policy
      assign rdy_next[gp] = ~(path_on[gp] & (txbuf_xoff[gp] |
        (rxbuf_full[gp] & ~ctrl_reg[gp][`HBT_C_DROP]))); // [R5] [R6]

      // taken by bmc, buffered, sent by bmc, received by host
      assign inc[gp*6+0] = bmc_took & me_t; // [R10]
      assign inc[gp*6+1] = h_acc & h_bmc & h_room & me_h; // [R10]
      assign inc[gp*6+2] = b_host & me_b; // [R10]
      assign inc[gp*6+3] = host_rx_done & me_r; // [R10]
      // network packets lost to a full manageability buffer
      assign inc[gp*6+4] = nmg_valid & mng_full & me_n; // [R7]
      // every packet the bmc hands over on this port
      assign inc[gp*6+5] = btx_valid & me_b;

      for (gk = 0; gk < `HBT_NCNT; gk = gk + 1)
      begin : g_cnt
        hbt_cnt u_cnt (
          .pclk(pclk),
          .presetn(presetn),
          .inc(inc[gp*6+gk]),
          .count(cnt_val[gp*6+gk])
        );
      end
    end
  endgenerate

  // ----------------------------------------
  // traffic event flops
  // ----------------------------------------
  // one pulse per event, one cycle after the event is seen
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      htx_ready_reg <= 2'b00;
      htx_fwd_bmc_reg <= 1'b0;
      htx_fwd_net_reg <= 1'b0;
      htx_drop_reg <= 1'b0;
      host_tx_stat_reg <= 1'b0;
      btx_fwd_host_reg <= 1'b0;
      btx_fwd_net_reg <= 1'b0;
      btx_drop_reg <= 1'b0;
      btx_port_reg <= 1'b0;
      host_rx_stat_reg <= 1'b0;
      net_tx_stat_reg <= 1'b0;
      nmg_accept_reg <= 1'b0;
    end
    else
    begin
      htx_ready_reg <= rdy_next; // [R5]
      htx_fwd_bmc_reg <= h_acc & h_bmc & h_room; // [R5]
      htx_fwd_net_reg <= h_acc & htx_flt_net; // [R1] [R3]
      htx_drop_reg <= h_acc & h_bmc & ~h_room; // [R6] [R7]
      // counted once even when sent to both net and bmc
      host_tx_stat_reg <= h_acc; // [R8]
      btx_fwd_host_reg <= b_host;
      btx_fwd_net_reg <= b_net;
      btx_drop_reg <= btx_valid & ~b_host & ~b_net;
      btx_port_reg <= bp;
      host_rx_stat_reg <= b_host; // [R9]
      net_tx_stat_reg <= b_net; // [R9]
      nmg_accept_reg <= nmg_valid & ~mng_full; // [R7]
    end
  end

  // ----------------------------------------
  // arp flops
  // ----------------------------------------
  // reply carries the mac of the port the request came in on
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      arp_reply_reg <= 1'b0;
      arp_port_reg <= 1'b0;
      arp_mac_reg <= `HBT_MAC_RST;
      arp_to_bmc_reg <= 1'b0;
    end
    else
    begin
      arp_reply_reg <= arp_valid & a_auto & a_hit; // [R20] [R21]
      arp_to_bmc_reg <= arp_valid & a_fwd; // [R22]
      if (arp_valid & a_auto & a_hit)
      begin
        arp_port_reg <= ap; // [R25]
        arp_mac_reg <= mac_reg[ap]; // [R25]
      end
    end
  end

  // ----------------------------------------
  // apb read and answer
  // ----------------------------------------
  wire [3:0] r_idx = hbt_dec(paddr); // register under the bus
  wire r_port = paddr[`HBT_PORT_BIT]; // bank under the bus
  wire [3:0] r_cidx = (r_port ? 4'h6 : 4'h0) + (r_idx - `HBT_I_CNT0);
  reg [31:0] r_data; // read mux

  // read mux; counters occupy the indices from the first counter on
  always @*
  begin
    r_data = 32'h0000_0000;
    case (r_idx)
      `HBT_I_CTRL: r_data = {26'h000_0000, ctrl_reg[r_port]};
      `HBT_I_ARP_IP: r_data = ip_reg[r_port];
      `HBT_I_MAC_LO: r_data = mac_reg[r_port][31:0];
      `HBT_I_MAC_HI: r_data = {16'h0000, mac_reg[r_port][47:32]};
      `HBT_I_FILTER: r_data = flt_reg[r_port];
      `HBT_I_STATUS: r_data = {28'h000_0000, ncsi_mode,
        link_up[r_port], path_on[r_port], htx_ready_reg[r_port]};
      `HBT_I_NONE: r_data = 32'h0000_0000;
      default: r_data = cnt_val[r_cidx];
    endcase
  end

  // answer in the first access cycle: data and error set at setup
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      pready_reg <= psel & ~penable;
      if (psel & ~penable)
      begin
        prdata_reg <= pwrite ? 32'h0000_0000 : r_data;
        pslverr_reg <= (r_idx == `HBT_I_NONE);
      end
      else
        pslverr_reg <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ---- rtl/hbt_unused_guard.v ----
// hbt_unused_guard.v: holds no logic.
`default_nettype none
`default_nettype wire

// ---- sim/hbt_bmc_model.sv ----
// hbt_bmc_model.sv: management controller on the sideband side.
// assumes: caller sequences the tasks; all changes follow a pclk edge.
`default_nettype none
module hbt_bmc_model (
  input wire logic pclk,
  output var logic sb_wr,
  output var logic [7:0] sb_addr,
  output var logic [31:0] sb_data,
  output var logic btx_valid,
  output var logic btx_port,
  output var logic [10:0] btx_len,
  output var logic btx_exact,
  output var logic btx_l2_pass,
  output var logic bmc_took,
  output var logic bmc_took_port
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle outputs from time zero
  initial
  begin
    {sb_wr, sb_addr, sb_data, btx_valid, btx_port, btx_len} = '0;
    {btx_exact, btx_l2_pass, bmc_took, bmc_took_port} = '0;
  end
  // sideband write pulse; data shows its inverse once released
  task sb_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    sb_wr <= 1'b1;
    sb_addr <= a;
    sb_data <= d;
    @(posedge pclk);
    sb_wr <= 1'b0;
    sb_data <= ~d;
  endtask
  // one frame; caller picks the port, so failover stays with us
  task send(input logic p, input logic [10:0] n, input logic ex, input logic l2);
    @(posedge pclk);
    btx_valid <= 1'b1;
    btx_port <= p;
    btx_len <= n;
    btx_exact <= ex;
    btx_l2_pass <= l2;
    @(posedge pclk);
    btx_valid <= 1'b0;
    btx_len <= ~n;
  endtask
  // report one host packet taken
  task took(input logic p);
    @(posedge pclk);
    bmc_took <= 1'b1;
    bmc_took_port <= p;
    @(posedge pclk);
    bmc_took <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- sim/hbt_steer_monitor.sv ----
// hbt_steer_monitor.sv: port-level assertions for the steering block.
// assumes: bound to hbt_steer; one clock, pclk; reset presetn low.
`default_nettype none
module hbt_steer_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic ncsi_mode,
  input wire logic [1:0] link_up,
  input wire logic htx_valid,
  input wire logic htx_port,
  input wire logic [10:0] htx_len,
  input wire logic [1:0] htx_ready,
  input wire logic htx_fwd_bmc,
  input wire logic host_tx_stat,
  input wire logic btx_valid,
  input wire logic [10:0] btx_len,
  input wire logic btx_drop,
  input wire logic btx_fwd_host,
  input wire logic btx_fwd_net,
  input wire logic host_rx_stat,
  input wire logic net_tx_stat,
  input wire logic nmg_valid,
  input wire logic mng_full,
  input wire logic nmg_accept,
  input wire logic arp_valid,
  input wire logic arp_port,
  input wire logic arp_reply,
  input wire logic arp_reply_port,
  input wire logic arp_to_bmc
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // one domain: shared clocking and reset
  // ----------------------------------------
  default clocking mc @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // zero-wait answer right after setup
  apb_answer_a: assert property (psel && !penable |=> pready)
    else $error("apb answer late");
  unmapped_err_a: assert property (psel && !penable && paddr[7] |=> pready && pslverr)
    else $error("unmapped access not refused");
  host_count_a: assert property (htx_valid && htx_ready[htx_port] |=> host_tx_stat)
    else $error("host packet not counted");
  link_block_a: assert property (htx_valid && htx_ready[htx_port] && !link_up[htx_port]
    |=> !htx_fwd_bmc) else $error("host to bmc with link down");
  host_len_a: assert property (htx_valid && htx_ready[htx_port] && htx_len > 11'h600
    |=> !htx_fwd_bmc) else $error("long host frame reached bmc");
  bmc_len_a: assert property (btx_valid && btx_len > 11'h600
    |=> btx_drop && !btx_fwd_host && !btx_fwd_net) else $error("long bmc frame passed");
  stat_pair_a: assert property (host_rx_stat == btx_fwd_host && net_tx_stat == btx_fwd_net)
    else $error("bmc statistics mismatch");
  ncsi_arp_a: assert property (arp_valid && ncsi_mode |=> !arp_reply && !arp_to_bmc)
    else $error("arp service in ncsi mode");
  reply_port_a: assert property (arp_reply |-> $past(arp_valid) &&
    arp_reply_port == $past(arp_port)) else $error("arp reply on wrong port");
  mng_drop_a: assert property (nmg_valid |=> nmg_accept == !$past(mng_full))
    else $error("manageability accept wrong");
  // main scenarios reached
  both_cov: cover property (btx_fwd_host && btx_fwd_net);
  reply_cov: cover property (arp_reply);
  err_cov: cover property (pslverr);
endmodule
bind hbt_steer hbt_steer_monitor mon (.*);
`default_nettype wire

// ---- sim/testbench.sv ----
// testbench.sv: self-checking bench for hbt_steer.
// assumes: hbt_steer, hbt_bmc_model and the monitor are compiled first.
`default_nettype none
`define CK(n, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD %s exp %0h got %0h", n, (e), (g)); end end
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk, presetn, psel, penable, pwrite, ncsi_mode, mng_full, nvm_wr;
  logic [7:0] paddr, nvm_addr, sb_addr;
  logic [31:0] pwdata, nvm_data, sb_data, prdata, arp_tip;
  logic [1:0] link_up, txbuf_xoff, rxbuf_full, htx_ready;
  logic htx_valid, htx_port, htx_flt_bmc, htx_flt_net, host_rx_done, host_rx_port;
  logic [10:0] htx_len, btx_len;
  logic nmg_valid, nmg_port, arp_valid, arp_port, arp_ok, sb_wr, pready, pslverr;
  logic btx_valid, btx_port, btx_exact, btx_l2_pass, bmc_took, bmc_took_port;
  logic htx_fwd_bmc, htx_fwd_net, htx_drop, host_tx_stat, btx_fwd_host, btx_fwd_net;
  logic btx_drop, btx_port_out, host_rx_stat, net_tx_stat, nmg_accept, arp_reply;
  logic arp_reply_port, arp_to_bmc;
  logic [47:0] arp_reply_mac;
  int checked, bad_count;
  hbt_steer dut (.*);
  hbt_bmc_model bmc (.*);
  // ----------------------------------------
  // clock, timeout and verdict
  // ----------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // a hang counts as a mismatch
  initial
  begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    wrap_up();
  end
  task wrap_up;
    $display("checked %0d bad %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ----------------------------------------
  // apb master and register helpers
  // ----------------------------------------
  function automatic logic [7:0] ad(input logic p, input logic [3:0] i);
    return {1'b0, p, i, 2'b00};
  endfunction
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  // read and compare; data is ignored on a refused access
  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] x,
                      input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    `CK(n, xe, e)
    if (!xe) `CK(n, x, r)
  endtask
  // ----------------------------------------
  // stimulus helpers
  // ----------------------------------------
  task automatic hsend(input logic p, input logic [10:0] n, input logic fb);
    @(posedge pclk);
    htx_valid <= 1'b1;
    htx_port <= p;
    htx_len <= n;
    htx_flt_bmc <= fb;
    htx_flt_net <= 1'b1;
    do @(posedge pclk); while (htx_ready[p] !== 1'b1);
    htx_valid <= 1'b0;
    #1;
  endtask
  task arp(input logic p, input logic [31:0] t);
    @(posedge pclk);
    arp_valid <= 1'b1;
    arp_port <= p;
    arp_ok <= 1'b1;
    arp_tip <= t;
    @(posedge pclk);
    arp_valid <= 1'b0;
    arp_tip <= ~t;
    #1;
  endtask
  task step(input logic [31:0] c, input logic ex, l2, input logic [10:0] n,
            input logic [2:0] x);
    wr(ad(1'b0, 4'h0), c);
    bmc.send(1'b0, n, ex, l2);
    #1;
    `CK("host net drop", x, {btx_fwd_host, btx_fwd_net, btx_drop})
    `CK("stats", x[2:1], {host_rx_stat, net_tx_stat})
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_regs;
    rchk("ctrl0 reset", ad(1'b0, 4'h0), 32'h0000_0000, 1'b0);
    wr(ad(1'b1, 4'h0), 32'h0000_003f);
    rchk("ctrl1", ad(1'b1, 4'h0), 32'h0000_003f, 1'b0);
    rchk("ctrl0 apart", ad(1'b0, 4'h0), 32'h0000_0000, 1'b0);
    @(posedge pclk);
    {nvm_wr, nvm_addr, nvm_data} <= {1'b1, ad(1'b0, 4'h4), 32'h0000_00a5};
    @(posedge pclk);
    nvm_wr <= 1'b0;
    rchk("nvm filter", ad(1'b0, 4'h4), 32'h0000_00a5, 1'b0);
    rchk("unmapped", 8'h80, 32'h0000_0000, 1'b1);
    rchk("index c", ad(1'b0, 4'hc), 32'h0000_0000, 1'b1);
    wr(ad(1'b1, 4'h0), 32'h0000_0000);
    $display("regs test done");
  endtask
  task t_steer;
    step(32'h0000_0001, 1'b0, 1'b0, 11'h040, 3'b010);
    step(32'h0000_0006, 1'b0, 1'b0, 11'h040, 3'b100);
    step(32'h0000_0007, 1'b1, 1'b1, 11'h040, 3'b100);
    step(32'h0000_0007, 1'b0, 1'b1, 11'h600, 3'b110);
    step(32'h0000_0007, 1'b0, 1'b0, 11'h040, 3'b010);
    step(32'h0000_0007, 1'b0, 1'b1, 11'h601, 3'b001);
    step(32'h0000_0000, 1'b0, 1'b1, 11'h040, 3'b001);
    bmc.send(1'b1, 11'h040, 1'b0, 1'b1);
    #1;
    `CK("port", 2'b11, {btx_port_out, btx_drop})
    $display("steer test done");
  endtask
  task t_host;
    bmc.sb_write(ad(1'b0, 4'h0), 32'h0000_0006);
    hsend(1'b0, 11'h040, 1'b1);
    `CK("to bmc", 3'b111, {htx_fwd_bmc, htx_fwd_net, host_tx_stat})
    hsend(1'b0, 11'h040, 1'b0);
    `CK("filtered", 2'b01, {htx_fwd_bmc, host_tx_stat})
    hsend(1'b0, 11'h601, 1'b1);
    `CK("long", 1'b0, htx_fwd_bmc)
    @(posedge pclk);
    mng_full <= 1'b1;
    hsend(1'b0, 11'h040, 1'b1);
    `CK("mng full", 1'b1, htx_drop)
    @(posedge pclk);
    mng_full <= 1'b0;
    link_up <= 2'b10;
    hsend(1'b0, 11'h040, 1'b1);
    `CK("link down", 2'b01, {htx_fwd_bmc, host_tx_stat})
    @(posedge pclk);
    link_up <= 2'b11;
    txbuf_xoff <= 2'b01;
    repeat (2) @(posedge pclk);
    #1;
    `CK("xoff", 2'b10, htx_ready)
    @(posedge pclk);
    txbuf_xoff <= 2'b00;
    rxbuf_full <= 2'b01;
    repeat (2) @(posedge pclk);
    #1;
    `CK("rx stall", 2'b10, htx_ready)
    bmc.took(1'b0);
    bmc.took(1'b0);
    @(posedge pclk);
    host_rx_done <= 1'b1;
    rxbuf_full <= 2'b00;
    @(posedge pclk);
    host_rx_done <= 1'b0;
    rchk("taken", ad(1'b0, 4'h6), 32'h0000_0002, 1'b0);
    rchk("received", ad(1'b0, 4'h9), 32'h0000_0001, 1'b0);
    $display("host test done");
  endtask
  task t_nmg;
    @(posedge pclk);
    mng_full <= 1'b1;
    nmg_valid <= 1'b1;
    @(posedge pclk);
    mng_full <= 1'b0;
    #1;
    `CK("refused", 1'b0, nmg_accept)
    @(posedge pclk);
    nmg_valid <= 1'b0;
    #1;
    `CK("accepted", 1'b1, nmg_accept)
    rchk("drops", ad(1'b0, 4'ha), 32'h0000_0001, 1'b0);
    $display("mng test done");
  endtask
  task t_arp;
    bmc.sb_write(ad(1'b1, 4'h1), 32'h0a00_0005);
    wr(ad(1'b1, 4'h2), 32'h3344_5566);
    wr(ad(1'b1, 4'h3), 32'h0000_1122);
    wr(ad(1'b1, 4'h0), 32'h0000_0008);
    arp(1'b1, 32'h0a00_0005);
    `CK("reply", 50'h3_1122_3344_5566, {arp_reply, arp_reply_port, arp_reply_mac})
    arp(1'b1, 32'h0a00_0006);
    `CK("no match", 2'b00, {arp_reply, arp_to_bmc})
    arp(1'b0, 32'h0a00_0005);
    `CK("other port", 1'b0, arp_reply)
    @(posedge pclk);
    ncsi_mode <= 1'b1;
    arp(1'b1, 32'h0a00_0005);
    `CK("ncsi", 1'b0, arp_reply)
    @(posedge pclk);
    ncsi_mode <= 1'b0;
    wr(ad(1'b1, 4'h0), 32'h0000_0010);
    arp(1'b1, 32'h0a00_0005);
    `CK("forward", 2'b01, {arp_reply, arp_to_bmc})
    $display("arp test done");
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, ncsi_mode, mng_full} = '0;
    {nvm_wr, nvm_addr, nvm_data, txbuf_xoff, rxbuf_full, arp_tip} = '0;
    {htx_valid, htx_port, htx_len, htx_flt_bmc, htx_flt_net, host_rx_port} = '0;
    {host_rx_done, nmg_valid, nmg_port, arp_valid, arp_port, arp_ok} = '0;
    {checked, bad_count} = '0;
    link_up = 2'b11;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_steer();
    t_host();
    t_nmg();
    t_arp();
    wrap_up();
  end
endmodule
`default_nettype wire
